// [hdl/dspb_serial_regs.vh]
// register map, field positions, reset values and timing counts of the dual serial port
// assumes a 32-bit apb slave; every register sits in the low bits of one aligned word
`ifndef DSPB_SERIAL_REGS_VH
`define DSPB_SERIAL_REGS_VH

// ----------------------------------------------------------------------------
// byte addresses
// ----------------------------------------------------------------------------
`define DSPB_ADDR_P0_CTRL    8'h00
`define DSPB_ADDR_P0_DATA    8'h04
`define DSPB_ADDR_P0_RELOAD  8'h08
`define DSPB_ADDR_P1_CTRL    8'h0c
`define DSPB_ADDR_P1_DATA    8'h10
`define DSPB_ADDR_P1_RELOAD  8'h14
`define DSPB_ADDR_CFG        8'h18

// ----------------------------------------------------------------------------
// control register fields (both ports)
// ----------------------------------------------------------------------------
`define DSPB_CTL_MODE_HI     7
`define DSPB_CTL_MODE_LO     6
`define DSPB_CTL_MP          5
`define DSPB_CTL_REN         4
`define DSPB_CTL_TB8         3
`define DSPB_CTL_RB8         2
`define DSPB_CTL_TI          1
`define DSPB_CTL_RI          0
`define DSPB_CTL_RESET       8'h00
`define DSPB_RELOAD_RESET    10'h000

// ----------------------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------------------
`define DSPB_CFG_SMOD        0
`define DSPB_CFG_T1SEL       1
`define DSPB_CFG_STOP2_P0    2
`define DSPB_CFG_STOP2_P1    3
`define DSPB_CFG_TH1_LSB     8
`define DSPB_CFG_TH1_MSB     15
`define DSPB_TH1_RESET       8'h00

// ----------------------------------------------------------------------------
// timing: 16 sample ticks per bit, sample in the middle
// ----------------------------------------------------------------------------
`define DSPB_TICK_LAST       4'hf
`define DSPB_TICK_MID        4'h7
`define DSPB_RELOAD_SPAN     13'h400
`define DSPB_TH1_SPAN        13'h100
`define DSPB_INT_MUL_FAST    13'h002
`define DSPB_INT_MUL_SLOW    13'h004
`define DSPB_T1_MUL_FAST     13'h00c
`define DSPB_T1_MUL_SLOW     13'h018
`define DSPB_FIX_TICK_FAST   13'h002
`define DSPB_FIX_TICK_SLOW   13'h004

`endif

// [hdl/dspb_serial_top.v]
// dual asynchronous serial port with baud generators, apb register access
// assumes one 100 MHz clock, synchronous active-high reset, rx pins already synchronous
//
// Overview of operation
// [RULE1] port zero timer-one rate: 2^smod * clk / (384 * (256 - th1))
// [RULE2] port zero internal rate: 2^smod * clk / (64 * (1024 - reload))
// [RULE3] port one rate only internal: clk / (32 * (1024 - reload))
// [RULE4] each port's internal reload value is ten bits wide
// [RULE5] double-rate bit scales port zero only, never port one
// [RULE6] receiver assembles bytes least significant bit first
// [RULE7] transmitter shifts bytes out least significant bit first
// [RULE8] port zero modes 1 and 3 use internal or timer-one rate
// [RULE9] port zero mode 2 runs fixed at clk/32 or clk/64
// [RULE10] port one mode 0 is nine-bit frame, mode 1 eight-bit frame
// [RULE11] port zero mode 0 does nothing; port one has only two modes
// [RULE12] rates 300 to 38400 baud, ninth bit as parity, one or two stops
// [RULE13] 38400 baud reachable with a 1.2288 MHz clock
// [RULE14] software supplies transmitted ninth bit; received ninth bit is reported
// [RULE15] each port has a multiprocessor enable bit
// [RULE16] seven-bit frames: software handles bit 7 itself
// [RULE17] no parity generator; parity comes from the processor's flag
// [RULE18] each port is governed by its own control register
// [RULE19] port zero mode bits: 00 none, 01 eight-bit, 10/11 nine-bit
// [RULE20] hardware sets done flags, software clears them
// [RULE21] receiver starts frames only while receive enable is set
// [RULE22] rx ninth bit holds stop bit in 8-bit mode, ninth bit otherwise
// [RULE23] writing the data register starts a send; received byte is held
// [RULE24] start bit found by falling edge, bits sampled mid-bit
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "dspb_serial_regs.vh"

module dspb_serial_top (
  input  wire        clk,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rxd0,
  input  wire        rxd1,
  output wire        txd0,
  output wire        txd1
);

  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam [3:0] RX_IDLE  = 4'h1;
  localparam [3:0] RX_START = 4'h2;
  localparam [3:0] RX_DATA  = 4'h4;
  localparam [3:0] RX_STOP  = 4'h8;
  localparam [1:0] TX_IDLE  = 2'h1;
  localparam [1:0] TX_SEND  = 2'h2;

  // --------------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------------
  // sample-tick period in clocks; one bit lasts sixteen ticks
  function [12:0] tickLimit;
    input       isPortOne;
    input       fixedRate;
    input       useTimer;
    input       smod;
    input [9:0] reload;
    input [7:0] th1;
    begin
      if (fixedRate)
        tickLimit = smod ? `DSPB_FIX_TICK_FAST : `DSPB_FIX_TICK_SLOW; // RULE9
      else if (useTimer && !isPortOne) // RULE8
        tickLimit = (`DSPB_TH1_SPAN - {5'h00, th1})
                    * (smod ? `DSPB_T1_MUL_FAST : `DSPB_T1_MUL_SLOW); // RULE1
      else if (isPortOne)
        tickLimit = (`DSPB_RELOAD_SPAN - {3'h0, reload}) * `DSPB_INT_MUL_FAST; // RULE3 RULE13
      else
        tickLimit = (`DSPB_RELOAD_SPAN - {3'h0, reload})
                    * (smod ? `DSPB_INT_MUL_FAST : `DSPB_INT_MUL_SLOW); // RULE2 RULE5
    end
  endfunction

  // mode decode shared by both ports
  function portActive;
    input       isPortOne;
    input [7:0] ctl;
    begin
      portActive = isPortOne | ctl[`DSPB_CTL_MODE_HI] | ctl[`DSPB_CTL_MODE_LO]; // RULE11 RULE19
    end
  endfunction

  function portNine;
    input       isPortOne;
    input [7:0] ctl;
    begin
      portNine = isPortOne ? ~ctl[`DSPB_CTL_MODE_HI] : ctl[`DSPB_CTL_MODE_HI]; // RULE10 RULE19
    end
  endfunction

  // --------------------------------------------------------------------------
  // apb slave: answer in the first access cycle
  // --------------------------------------------------------------------------
  reg        smod_r;
  reg        t1Sel_r;
  reg  [1:0] stop2_r;
  reg  [7:0] th1_r;
  wire       accessDone = psel & penable & pready;
  wire       wrEn       = accessDone & pwrite;
  wire       rdEn       = accessDone & ~pwrite;
  wire [7:0] ctlRd [0:1];
  wire [7:0] bufRd [0:1];
  wire [9:0] relRd [0:1];
  wire [1:0] txLine;
  reg [31:0] rdMux;
  reg        addrOk;

  always @*
  begin
    rdMux  = 32'h0000_0000;
    addrOk = 1'b1;
    case ({paddr[7:2], 2'b00})
      `DSPB_ADDR_P0_CTRL:   rdMux = {24'h00_0000, ctlRd[0]};
      `DSPB_ADDR_P0_DATA:   rdMux = {24'h00_0000, bufRd[0]};
      `DSPB_ADDR_P0_RELOAD: rdMux = {22'h00_0000, relRd[0]};
      `DSPB_ADDR_P1_CTRL:   rdMux = {24'h00_0000, ctlRd[1]};
      `DSPB_ADDR_P1_DATA:   rdMux = {24'h00_0000, bufRd[1]};
      `DSPB_ADDR_P1_RELOAD: rdMux = {22'h00_0000, relRd[1]};
      `DSPB_ADDR_CFG:       rdMux = {16'h0000, th1_r, 4'h0, stop2_r, t1Sel_r, smod_r};
      default:              addrOk = 1'b0;
    endcase
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      // ready rises after the setup edge, falls after the access edge
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addrOk;
      if (psel && !penable && !pwrite)
        prdata <= rdMux;
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      smod_r  <= 1'b0;
      t1Sel_r <= 1'b0;
      stop2_r <= 2'b00;
      th1_r   <= `DSPB_TH1_RESET;
    end
    else if (wrEn && ({paddr[7:2], 2'b00} == `DSPB_ADDR_CFG))
    begin
      smod_r  <= pwdata[`DSPB_CFG_SMOD];
      t1Sel_r <= pwdata[`DSPB_CFG_T1SEL];
      stop2_r <= pwdata[`DSPB_CFG_STOP2_P1:`DSPB_CFG_STOP2_P0]; // RULE12
      th1_r   <= pwdata[`DSPB_CFG_TH1_MSB:`DSPB_CFG_TH1_LSB];
    end
  end

  assign txd0 = txLine[0];
  assign txd1 = txLine[1];

  // --------------------------------------------------------------------------
  // per-port baud divider, transmitter and receiver
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : port
      localparam ONE = (g == 1);
      wire [7:0] base = (g == 1) ? `DSPB_ADDR_P1_CTRL : `DSPB_ADDR_P0_CTRL;
      wire [7:0] waddr = {paddr[7:2], 2'b00};
      wire       wrCtl = wrEn & (waddr == base);
      wire       wrDat = wrEn & (waddr == base + 8'h04);
      wire       wrRel = wrEn & (waddr == base + 8'h08);
      wire       rxPin = (g == 1) ? rxd1 : rxd0;

      reg  [7:0]  ctl_r;
      reg  [9:0]  reload_r;
      reg  [7:0]  rxBuf_r;
      reg  [12:0] div_r;
      reg         tick_r;
      reg  [1:0]  txState_r;
      reg  [10:0] txSr_r;
      reg  [3:0]  txLeft_r;
      reg  [3:0]  txTc_r;
      reg         txd_r;
      reg  [3:0]  rxState_r;
      reg  [8:0]  rxSr_r;
      reg  [3:0]  rxBits_r;
      reg  [3:0]  rxTc_r;
      reg         rxPrev_r;
      reg         txDone;
      reg         rxDone;
      reg         rxNinth;

      wire active = portActive(ONE, ctl_r);
      wire nine   = portNine(ONE, ctl_r);
      wire fixed  = !ONE && (ctl_r[7:6] == 2'b10);
      wire stop2  = stop2_r[g];
      wire mp     = ctl_r[`DSPB_CTL_MP];
      wire ren    = ctl_r[`DSPB_CTL_REN];
      wire [12:0] limit = tickLimit(ONE, fixed, t1Sel_r, smod_r, reload_r, th1_r);
      // 8-bit frames take data from the upper shift bits, 9-bit from the lower
      wire [7:0] rxByte = nine ? rxSr_r[7:0] : rxSr_r[8:1];
      // multiprocessor filter: only address frames or valid stops complete
      wire rxAccept = !mp || (nine ? rxSr_r[8] : rxPin); // RULE15

      assign ctlRd[g] = ONE ? {ctl_r[7], 1'b0, ctl_r[5:0]} : ctl_r; // RULE18
      assign bufRd[g] = rxBuf_r;
      assign relRd[g] = reload_r;
      assign txLine[g] = txd_r;

      always @(posedge clk)
      begin
        if (srst)
        begin
          div_r  <= 13'h0000;
          tick_r <= 1'b0;
        end
        else if (div_r >= limit - 13'h0001)
        begin
          div_r  <= 13'h0000;
          tick_r <= 1'b1;
        end
        else
        begin
          div_r  <= div_r + 13'h0001;
          tick_r <= 1'b0;
        end
      end

      always @(posedge clk)
      begin
        if (srst)
        begin
          txState_r <= TX_IDLE;
          txSr_r    <= 11'h7ff;
          txLeft_r  <= 4'h0;
          txTc_r    <= 4'h0;
          txd_r     <= 1'b1;
          txDone    <= 1'b0;
        end
        else
        begin
          txDone <= 1'b0;
          case (txState_r)
            TX_IDLE:
            begin
              if (wrDat && active) // RULE23
              begin
                txd_r     <= 1'b0;
                // ninth bit from software; parity is computed by the cpu
                txSr_r    <= {2'b11, nine ? ctl_r[`DSPB_CTL_TB8] : 1'b1,
                              pwdata[7:0]}; // RULE14 RULE17
                txLeft_r  <= 4'h9 + {3'h0, nine} + {3'h0, stop2}; // RULE12
                txTc_r    <= 4'h0;
                txState_r <= TX_SEND;
              end
            end
            TX_SEND:
            begin
              if (tick_r)
              begin
                txTc_r <= txTc_r + 4'h1;
                if (txTc_r == `DSPB_TICK_LAST)
                begin
                  if (txLeft_r == 4'h0)
                  begin
                    txState_r <= TX_IDLE;
                    txDone    <= 1'b1;
                  end
                  else
                  begin
                    txd_r    <= txSr_r[0]; // RULE7
                    txSr_r   <= {1'b1, txSr_r[10:1]};
                    txLeft_r <= txLeft_r - 4'h1;
                  end
                end
              end
            end
            default:
            begin
              txState_r <= TX_IDLE;
              txd_r     <= 1'b1;
            end
          endcase
        end
      end

      always @(posedge clk)
      begin
        if (srst)
        begin
          rxState_r <= RX_IDLE;
          rxSr_r    <= 9'h000;
          rxBits_r  <= 4'h0;
          rxTc_r    <= 4'h0;
          rxPrev_r  <= 1'b1;
          rxDone    <= 1'b0;
          rxNinth   <= 1'b0;
        end
        else
        begin
          rxPrev_r <= rxPin;
          rxDone   <= 1'b0;
          if (!ren || !active) // RULE21
            rxState_r <= RX_IDLE;
          else
          begin
            case (rxState_r)
              RX_IDLE:
              begin
                if (rxPrev_r && !rxPin) // RULE24
                begin
                  rxTc_r    <= 4'h0;
                  rxState_r <= RX_START;
                end
              end
              RX_START:
              begin
                if (tick_r)
                begin
                  rxTc_r <= rxTc_r + 4'h1;
                  if (rxTc_r == `DSPB_TICK_MID)
                  begin
                    // a glitch shorter than half a bit is not a start
                    rxState_r <= rxPin ? RX_IDLE : RX_DATA; // RULE24
                    rxTc_r    <= 4'h0;
                    rxBits_r  <= 4'h0;
                  end
                end
              end
              RX_DATA:
              begin
                if (tick_r)
                begin
                  rxTc_r <= rxTc_r + 4'h1;
                  if (rxTc_r == `DSPB_TICK_LAST)
                  begin
                    rxSr_r   <= {rxPin, rxSr_r[8:1]}; // RULE6
                    rxBits_r <= rxBits_r + 4'h1;
                    if (rxBits_r == (nine ? 4'h8 : 4'h7))
                      rxState_r <= RX_STOP;
                  end
                end
              end
              RX_STOP:
              begin
                if (tick_r)
                begin
                  rxTc_r <= rxTc_r + 4'h1;
                  if (rxTc_r == `DSPB_TICK_LAST)
                  begin
                    rxState_r <= RX_IDLE;
                    rxDone    <= rxAccept;
                    rxNinth   <= nine ? rxSr_r[8] : rxPin; // RULE22
                  end
                end
              end
              default:
                rxState_r <= RX_IDLE;
            endcase
          end
        end
      end

      // control register: a hardware event wins over a software clear
      always @(posedge clk)
      begin
        if (srst)
        begin
          ctl_r    <= `DSPB_CTL_RESET;
          reload_r <= `DSPB_RELOAD_RESET;
          rxBuf_r  <= 8'h00;
        end
        else
        begin
          if (wrCtl)
            ctl_r <= pwdata[7:0];
          if (wrRel)
            reload_r <= pwdata[9:0]; // RULE4
          if (txDone)
            ctl_r[`DSPB_CTL_TI] <= 1'b1; // RULE20
          // byte is held until software clears the receive flag; a clear in the same
          // cycle as a new byte lets the byte in, so the hardware set wins
          if (rxDone && (!ctl_r[`DSPB_CTL_RI] || (wrCtl && !pwdata[`DSPB_CTL_RI])))
          begin
            rxBuf_r             <= rxByte; // RULE23
            ctl_r[`DSPB_CTL_RB8] <= rxNinth; // RULE14
            ctl_r[`DSPB_CTL_RI] <= 1'b1; // RULE20
          end
        end
      end
    end
  endgenerate

endmodule // dspb_serial_top

// [dv/dspb_serial_props.sv]
// assertions on the dual serial port top-level pins, bound from the bench
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`include "dspb_serial_regs.vh"

module dspb_serial_props (
  input logic        clk,
  input logic        srst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        rxd0,
  input logic        rxd1,
  input logic        txd0,
  input logic        txd1
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  logic [1:0] p0Mode_r;
  wire        wrDone;

  assign wrDone = psel && penable && pready && pwrite;

  // shadow of the mode bits, so inactive-port checks follow software
  always @(posedge clk)
    if (srst)
      p0Mode_r <= 2'b00;
    else if (wrDone && paddr[7:2] == 6'h00)
      p0Mode_r <= pwdata[7:6];

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  ready_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held over one cycle");
  unmapped_error_a: assert property (pready |-> pslverr == (paddr[7:2] > 6'h06))
    else $error("error response does not match address");
  error_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  zero_inactive_a: assert property (p0Mode_r == 2'b00 |-> txd0)
    else $error("inactive port zero drove its line");
  bit_hold0_a: assert property ($changed(txd0) |=> $stable(txd0) [*8])
    else $error("port zero bit shorter than one bit time");
  bit_hold1_a: assert property ($changed(txd1) |=> $stable(txd1) [*8])
    else $error("port one bit shorter than one bit time");
  tx_launch_a: assert property (wrDone && paddr == `DSPB_ADDR_P1_DATA && txd1 |=> !txd1)
    else $error("data write did not start a frame");
  reset_idle_a: assert property ($fell(srst) |-> txd0 && txd1 && !pready)
    else $error("outputs not idle after reset");

  cover property (pslverr);
  cover property ($fell(txd0));
  cover property (wrDone && paddr == `DSPB_ADDR_P1_DATA);
endmodule // dspb_serial_props

// [dv/dspb_serial_host.sv]
// far-side serial model: sends frames on the receive pins, decodes the transmit pins
// assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/1ps

module dspb_serial_host (
  input  logic clk,
  input  logic txd0,
  input  logic txd1,
  output logic rxd0,
  output logic rxd1
);
  // idle mark level between frames
  initial
  begin
    rxd0 = 1'b1;
    rxd1 = 1'b1;
  end

  // start, data lsb first, ninth bit when nb is 9, one stop
  task automatic sendFrame(input int p, input int bt, input int nb, input logic [8:0] d);
    logic [10:0] f;
    int          i;
    f = (nb == 9) ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
    for (i = 0; i < nb + 2; i++)
    begin
      if (p == 1)
        rxd1 <= f[i];
      else
        rxd0 <= f[i];
      repeat (bt) @(posedge clk);
    end
  endtask

  // mid-bit sampling; a missing start or a low stop returns unknown
  task automatic getFrame(input int p, input int bt, input int nb, output logic [8:0] d);
    int   i;
    logic bad;
    d = 9'h000;
    for (i = 0; i < 5000 && (p == 1 ? txd1 : txd0) !== 1'b0; i++)
      @(posedge clk);
    repeat (bt / 2) @(posedge clk);
    bad = (p == 1 ? txd1 : txd0) !== 1'b0;
    for (i = 0; i < nb; i++)
    begin
      repeat (bt) @(posedge clk);
      d[i] = p == 1 ? txd1 : txd0;
    end
    repeat (bt) @(posedge clk);
    if (bad || (p == 1 ? txd1 : txd0) !== 1'b1)
      d = 9'bx;
    repeat (bt) @(posedge clk);
  endtask
endmodule // dspb_serial_host

// [dv/dual_serial_port_with_baud_gen_test.sv]
// self-checking bench for the dual serial port: apb master, lfsr data, queue model
// assumes the host model on the serial pins and the checker bound at the foot
`timescale 1ns/1ps
`include "dspb_serial_regs.vh"

module dual_serial_port_with_baud_gen_test;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd0;
  logic        rxd1;
  logic        txd0;
  logic        txd1;
  logic [31:0] seed = 32'hd7ecfe7a;
  logic [8:0]  expQ[$];
  logic [7:0]  lastRx [0:1] = '{8'h00, 8'h00};
  int          failures = 0;
  int          numChecks = 0;

  always #5 clk = ~clk;

  dspb_serial_top i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd0(rxd0), .rxd1(rxd1), .txd0(txd0), .txd1(txd1));
  dspb_serial_host i_host (.clk(clk), .txd0(txd0), .txd1(txd1), .rxd0(rxd0), .rxd1(rxd1));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d errors %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one idle cycle after each transfer keeps drivers off a shared time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      failures++;
      $display("Error apb ready expected 1 seen 0");
      complete_run;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic runTx(input int p, input logic [7:0] c, input logic [31:0] cf,
                       input logic [9:0] rl, input int bt, input int nb);
    logic [7:0]  b;
    logic [8:0]  got;
    logic [31:0] rd;
    logic        er;
    seed = lfsr(seed);
    if (p == 1 && nb == 8)
      seed[7] = 1'b1;
    b = p == 1 ? `DSPB_ADDR_P1_CTRL : `DSPB_ADDR_P0_CTRL;
    expQ.push_back({nb == 9 ? c[3] : 1'b0, seed[7:0]});
    apb(1'b1, `DSPB_ADDR_CFG, cf, rd, er);
    apb(1'b1, b + 8'h08, {22'h0, rl}, rd, er);
    apb(1'b1, b, {24'h0, c}, rd, er);
    fork
      i_host.getFrame(p, bt, nb, got);
      apb(1'b1, b + 8'h04, seed, rd, er);
    join
    // a second stop bit ends the frame half a bit time after the host returns
    repeat (bt) @(posedge clk);
    chk("tx frame", {23'h0, expQ.pop_front()}, {23'h0, got});
    apb(1'b0, b, 32'h0, rd, er);
    chk("tx done", 32'h1, {31'h0, rd[1]});
    apb(1'b1, b, {24'h0, c}, rd, er);
  endtask

  task automatic runRx(input int p, input logic [7:0] c, input int bt, input int nb,
                       input logic en);
    logic [7:0]  b;
    logic [31:0] rd;
    logic        er;
    logic        acc;
    seed = lfsr(seed);
    b = p == 1 ? `DSPB_ADDR_P1_CTRL : `DSPB_ADDR_P0_CTRL;
    // multiprocessor filter: a nine-bit frame completes only with its ninth bit set
    acc = en & (!c[5] | nb == 8 | seed[8]);
    if (acc)
      lastRx[p] = seed[7:0];
    apb(1'b1, b, {24'h0, c}, rd, er);
    i_host.sendFrame(p, bt, nb, seed[8:0]);
    apb(1'b0, b, 32'h0, rd, er);
    chk("rx done", {31'h0, acc}, {31'h0, rd[0]});
    chk("rx ninth", {31'h0, acc & (nb == 8 | seed[8])}, {31'h0, rd[2]});
    apb(1'b0, b + 8'h04, 32'h0, rd, er);
    chk("rx data", {24'h0, lastRx[p]}, rd);
    apb(1'b1, b, {24'h0, c}, rd, er);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] rd;
    logic        er;
    int          a;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (a = 0; a < 28; a += 4)
    begin
      apb(1'b0, a[7:0], 32'h0, rd, er);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b0, 8'h1c, 32'h0, rd, er);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b1, `DSPB_ADDR_P0_RELOAD, 32'hffffffff, rd, er);
    apb(1'b0, `DSPB_ADDR_P0_RELOAD, 32'h0, rd, er);
    chk("reload width", 32'h3ff, rd);
    runTx(0, 8'h40, 32'h1, 10'h3ff, 64 * (1024 - 1023) / 2, 8);
    runTx(0, 8'hc8, 32'hff02, 10'h3ff, 384 * (256 - 255), 9);
    runTx(0, 8'h80, 32'h0, 10'h3ff, 64, 9);
    runTx(1, 8'h08, 32'h1, 10'h3fe, 32 * (1024 - 1022), 9);
    runTx(1, 8'h80, 32'h8, 10'h3ff, 32 * (1024 - 1023), 8);
    runRx(1, 8'h80, 32, 8, 1'b0);
    runRx(1, 8'h90, 32, 8, 1'b1);
    runRx(0, 8'h90, 64, 9, 1'b1);
    runRx(0, 8'hb0, 64, 9, 1'b1);
    apb(1'b1, `DSPB_ADDR_P0_CTRL, 32'h0, rd, er);
    apb(1'b1, `DSPB_ADDR_P0_DATA, 32'h5a, rd, er);
    repeat (100) @(posedge clk);
    chk("idle line", 32'h1, {31'h0, txd0});
    complete_run;
  end

  // hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    failures++;
    complete_run;
  end
endmodule // dual_serial_port_with_baud_gen_test

bind dspb_serial_top dspb_serial_props i_props (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd0(rxd0), .rxd1(rxd1), .txd0(txd0), .txd1(txd1));
